//--- src/dspt_channel.sv
`timescale 1ns/10ps
module dspt_channel #(
  parameter int W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              tick_i,
  input  wire logic              enable_i,
  input  wire logic              toggle_ok_i,
  input  wire dspt_pkg::dspt_com_t com_i,
  input  wire logic              dir_out_i,
  input  wire logic              counting_up_i,
  input  wire logic [W-1:0]      count_i,
  input  wire logic [W-1:0]      cmp_i,
  output logic                   match_o,
  output logic                   pin_o,
  output logic                   pin_oe_o
);
  logic wave_reg;
  logic connected;
  assign match_o = tick_i && enable_i && (count_i == cmp_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_reg <= 1'b0;
    end else if (match_o) begin
      unique case (com_i)
        dspt_pkg::COM_NONINV: wave_reg <= ~counting_up_i;
        dspt_pkg::COM_INV:    wave_reg <= counting_up_i;
        dspt_pkg::COM_TOGGLE: wave_reg <= toggle_ok_i ? ~wave_reg : wave_reg;
        dspt_pkg::COM_OFF:    wave_reg <= wave_reg;
      endcase
    end
  end
  assign connected = enable_i && ((com_i == dspt_pkg::COM_NONINV) || (com_i == dspt_pkg::COM_INV)
                     || ((com_i == dspt_pkg::COM_TOGGLE) && toggle_ok_i));
  assign pin_oe_o = connected && dir_out_i;
  assign pin_o    = wave_reg;
endmodule : dspt_channel

//--- src/dspt_pkg.sv
package dspt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CAPTOP  = 8'h04;
  localparam logic [7:0] OFS_CMPA    = 8'h08;
  localparam logic [7:0] OFS_CMPB    = 8'h0C;
  localparam logic [7:0] OFS_COUNT   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_CLEAR   = 8'h18;
  localparam logic [7:0] OFS_ENABLE  = 8'h1C;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_PRE_LSB  = 8;
  localparam int CTRL_DIRA_BIT = 11;
  localparam int CTRL_DIRB_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // waveform modes of this block
  localparam logic [3:0] MODE_PFC_CAPTOP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA   = 4'h9;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] BOTTOM  = 16'h0000;
  // status bit positions
  localparam int ST_OVF  = 0;
  localparam int ST_CMPA = 1;
  localparam int ST_CMPB = 2;
  localparam int ST_CAP  = 3;
  localparam int ST_W    = 4;
  typedef enum logic [1:0] {
    COM_OFF    = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_NONINV = 2'h2,
    COM_INV    = 2'h3
  } dspt_com_t;
  typedef struct packed {
    logic             dir_b;
    logic             dir_a;
    logic [2:0]       prescale;
    dspt_com_t        com_b;
    dspt_com_t        com_a;
    logic [3:0]       mode;
  } dspt_ctrl_t;
  typedef struct packed {
    logic cap;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } dspt_evt_t;
endpackage : dspt_pkg

//--- src/dspt_prescaler.sv
`timescale 1ns/10ps
module dspt_prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);
  logic [9:0] div_reg;
  logic [9:0] div_next;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_next;
    end
  end
  assign div_next = div_reg + 10'h001;
  // select 0 stops the timer; 1..5 give /1, /8, /64, /256, /1024
  // prescale factors
  always_comb begin
    unique case (sel_i)
      3'h1:    tick_o = 1'b1;
      3'h2:    tick_o = (div_reg[2:0] == 3'h7);
      3'h3:    tick_o = (div_reg[5:0] == 6'h3F);
      3'h4:    tick_o = (div_reg[7:0] == 8'hFF);
      3'h5:    tick_o = (div_reg == 10'h3FF);
      default: tick_o = 1'b0;
    endcase
  end
endmodule : dspt_prescaler

//--- src/dspt_timer.sv
`timescale 1ns/10ps
// Behaviour
// - dual-slope phase/frequency correct mode runs for mode values 8 and 9
// - counter runs zero to top, then top back to zero, per tick
// - top from capture register in mode 8, compare A in mode 9
// - counter holds top value for exactly one tick before descending
// - top ranges from three up to full sixteen-bit maximum
// - non-inverting clears on up-match, sets on down-match; inverting reversed
// - output mode two is non-inverted PWM, three inverted PWM
// - compare buffers load at bottom; overflow flag set same tick
// - at top, set compare A flag or capture flag per top source
// - compare-match flag set on each tick in a dual-slope mode where counter equals active compare value
// - compare output reaches pin only when direction bit selects output
// - frequency is clock over two times prescale times top
// - compare zero gives constant low, equal top gives high, non-inverted
// - single clock with asynchronous reset; prescaled tick is a clock enable
// - output mode one toggles A when upper mode bit set, else off
// - output mode zero disconnects both compare outputs
module dspt_timer (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  output logic             COMPARE_OUTPUT_A_O,
  output logic             COMPARE_OUTPUT_A_OE_O,
  output logic             COMPARE_OUTPUT_B_O,
  output logic             COMPARE_OUTPUT_B_OE_O
);
  localparam int W = 16;

  dspt_pkg::dspt_ctrl_t ctrl_reg;
  logic [W-1:0]         capture_top_register_reg;
  logic [W-1:0]         cmp_a_buf_reg;
  logic [W-1:0]         cmp_b_buf_reg;
  logic [W-1:0]         compare_value_a_reg;
  logic [W-1:0]         compare_value_b_reg;
  logic [W-1:0]         counter_value_reg;
  logic                 counting_up_reg;
  logic [dspt_pkg::ST_W-1:0] status_reg;
  logic [dspt_pkg::ST_W-1:0] irq_en_reg;
  logic [31:0]          prdata_reg;
  logic                 timer_tick;
  logic                 pfc_mode;
  logic [W-1:0]         top_value;
  logic                 at_top;
  logic                 at_bottom;
  logic                 slope_up;
  logic                 match_a;
  logic                 match_b;
  logic                 wr_en;
  logic                 rd_en;
  logic [dspt_pkg::ST_W-1:0] evt;
  logic [dspt_pkg::ST_W-1:0] clr;

  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign PRDATA_O = prdata_reg;

  dspt_prescaler u_pre (
    .clk_i  (MCLK_I),
    .rst_i  (RST_I),
    .sel_i  (ctrl_reg.prescale),
    .tick_o (timer_tick)
  );

  assign pfc_mode = (ctrl_reg.mode == dspt_pkg::MODE_PFC_CAPTOP) ||
                    (ctrl_reg.mode == dspt_pkg::MODE_PFC_CMPA);
  assign top_value = (ctrl_reg.mode == dspt_pkg::MODE_PFC_CMPA) ? compare_value_a_reg
                                                                : capture_top_register_reg;
  assign at_top    = (counter_value_reg == top_value);
  assign at_bottom = (counter_value_reg == dspt_pkg::BOTTOM);
  // compare units see the slope of the next step, so a compare at either end gives a steady level
  // slope at ends
  assign slope_up  = at_bottom || (counting_up_reg && !at_top);

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_reg                 <= dspt_pkg::dspt_ctrl_t'(dspt_pkg::CTRL_RESET[12:0]);
      capture_top_register_reg <= 16'hFFFF;
      cmp_a_buf_reg            <= 16'h0000;
      cmp_b_buf_reg            <= 16'h0000;
      irq_en_reg               <= 4'h0;
    end else if (wr_en) begin
      unique case (PADDR_I)
        dspt_pkg::OFS_CTRL:   ctrl_reg <= dspt_pkg::dspt_ctrl_t'(PWDATA_I[12:0]);
        dspt_pkg::OFS_CAPTOP: capture_top_register_reg <= PWDATA_I[15:0];
        dspt_pkg::OFS_CMPA:   cmp_a_buf_reg <= PWDATA_I[15:0];
        dspt_pkg::OFS_CMPB:   cmp_b_buf_reg <= PWDATA_I[15:0];
        dspt_pkg::OFS_ENABLE: irq_en_reg <= PWDATA_I[3:0];
        default:              ;
      endcase
    end
  end

  // a count write wins over the tick so software can re-phase the slopes
  // dual-slope count
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      counter_value_reg <= 16'h0000;
      counting_up_reg   <= 1'b1;
    end else if (wr_en && PADDR_I == dspt_pkg::OFS_COUNT) begin
      counter_value_reg <= PWDATA_I[15:0];
    end else if (timer_tick && pfc_mode) begin
      if (counting_up_reg) begin
        if (at_top) begin
          counting_up_reg   <= 1'b0;
          counter_value_reg <= counter_value_reg - 16'h0001;
        end else begin
          counter_value_reg <= counter_value_reg + 16'h0001;
        end
      end else if (at_bottom) begin
        counting_up_reg   <= 1'b1;
        counter_value_reg <= counter_value_reg + 16'h0001;
      end else begin
        counter_value_reg <= counter_value_reg - 16'h0001;
      end
    end
  end

  // outside the dual-slope modes the buffers are transparent, so a later start begins with fresh values
  // reload at bottom
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      compare_value_a_reg <= 16'h0000;
      compare_value_b_reg <= 16'h0000;
    end else if (!pfc_mode || (timer_tick && at_bottom)) begin
      compare_value_a_reg <= cmp_a_buf_reg;
      compare_value_b_reg <= cmp_b_buf_reg;
    end
  end

  // channel A toggle allowed by upper mode bit
  dspt_channel #(.W(W)) u_ch_a (
    .clk_i         (MCLK_I),
    .rst_i         (RST_I),
    .tick_i        (timer_tick),
    .enable_i      (pfc_mode),
    .toggle_ok_i   (ctrl_reg.mode[3]),
    .com_i         (ctrl_reg.com_a),
    .dir_out_i     (ctrl_reg.dir_a),
    .counting_up_i (slope_up),
    .count_i       (counter_value_reg),
    .cmp_i         (compare_value_a_reg),
    .match_o       (match_a),
    .pin_o         (COMPARE_OUTPUT_A_O),
    .pin_oe_o      (COMPARE_OUTPUT_A_OE_O)
  );

  // channel B toggle reserved, kept disconnected
  dspt_channel #(.W(W)) u_ch_b (
    .clk_i         (MCLK_I),
    .rst_i         (RST_I),
    .tick_i        (timer_tick),
    .enable_i      (pfc_mode),
    .toggle_ok_i   (1'b0),
    .com_i         (ctrl_reg.com_b),
    .dir_out_i     (ctrl_reg.dir_b),
    .counting_up_i (slope_up),
    .count_i       (counter_value_reg),
    .cmp_i         (compare_value_b_reg),
    .match_o       (match_b),
    .pin_o         (COMPARE_OUTPUT_B_O),
    .pin_oe_o      (COMPARE_OUTPUT_B_OE_O)
  );

  always_comb begin
    evt = '0;
    evt[dspt_pkg::ST_OVF]  = pfc_mode && timer_tick && at_bottom;
    evt[dspt_pkg::ST_CMPA] = match_a;
    evt[dspt_pkg::ST_CMPB] = match_b;
    evt[dspt_pkg::ST_CAP]  = pfc_mode && timer_tick && at_top &&
                             (ctrl_reg.mode == dspt_pkg::MODE_PFC_CAPTOP);
  end
  assign clr = (wr_en && PADDR_I == dspt_pkg::OFS_CLEAR) ? PWDATA_I[3:0] : 4'h0;

  // set wins over clear
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~clr) | evt;
    end
  end
  assign IRQ_O = |(status_reg & irq_en_reg);

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_reg <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        dspt_pkg::OFS_CTRL:   prdata_reg <= {19'h0_0000, ctrl_reg};
        dspt_pkg::OFS_CAPTOP: prdata_reg <= {16'h0000, capture_top_register_reg};
        dspt_pkg::OFS_CMPA:   prdata_reg <= {16'h0000, cmp_a_buf_reg};
        dspt_pkg::OFS_CMPB:   prdata_reg <= {16'h0000, cmp_b_buf_reg};
        dspt_pkg::OFS_COUNT:  prdata_reg <= {counting_up_reg, 15'h0000, counter_value_reg};
        dspt_pkg::OFS_STATUS: prdata_reg <= {28'h000_0000, status_reg};
        dspt_pkg::OFS_ENABLE: prdata_reg <= {28'h000_0000, irq_en_reg};
        default:              prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // a period that saw a bus write or another mode is not judged, its top may have moved
  // ticks per period
  logic [W:0] period_ticks_reg;
  logic       period_clean_reg;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      period_ticks_reg <= '0;
      period_clean_reg <= 1'b0;
    end else if (pfc_mode && timer_tick && at_bottom) begin
      period_ticks_reg <= {{W{1'b0}}, 1'b1};
      period_clean_reg <= !wr_en;
    end else begin
      if (pfc_mode && timer_tick) begin
        period_ticks_reg <= period_ticks_reg + {{W{1'b0}}, 1'b1};
      end
      if (wr_en || !pfc_mode) begin
        period_clean_reg <= 1'b0;
      end
    end
  end

  // assertions
  AST_TOP_TURN: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && timer_tick && counting_up_reg && at_top && top_value != 16'h0000 &&
     !(wr_en && PADDR_I == dspt_pkg::OFS_COUNT)) |=> !counting_up_reg &&
     counter_value_reg == $past(counter_value_reg) - 16'h0001)
    else $error("counter did not turn at top");
  AST_BOTTOM_TURN: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && timer_tick && !counting_up_reg && at_bottom && !wr_en) |=> counting_up_reg &&
     counter_value_reg == 16'h0001)
    else $error("counter did not turn at bottom");
  AST_OVF_SET: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && timer_tick && at_bottom) |=> status_reg[dspt_pkg::ST_OVF] &&
     compare_value_a_reg == $past(cmp_a_buf_reg))
    else $error("overflow flag or reload missing at bottom");
  AST_HOLD_NO_TICK: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (!timer_tick && !wr_en) |=> $stable(counter_value_reg))
    else $error("counter moved without tick");
  AST_CAP_FLAG: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (timer_tick && at_top && ctrl_reg.mode == dspt_pkg::MODE_PFC_CAPTOP) |=> status_reg[dspt_pkg::ST_CAP])
    else $error("capture flag not set at top");
  AST_CMPA_FLAG: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && timer_tick && counter_value_reg == compare_value_a_reg) |=> status_reg[dspt_pkg::ST_CMPA])
    else $error("compare A flag not set");
  AST_NONINV_UP: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (match_a && ctrl_reg.com_a == dspt_pkg::COM_NONINV && slope_up) |=> !COMPARE_OUTPUT_A_O)
    else $error("non-inverted output not cleared on up match");
  AST_INV_UP: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (match_a && ctrl_reg.com_a == dspt_pkg::COM_INV && slope_up) |=> COMPARE_OUTPUT_A_O)
    else $error("inverted output not set on up match");
  AST_NONINV_DOWN: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (match_b && ctrl_reg.com_b == dspt_pkg::COM_NONINV && !slope_up) |=> COMPARE_OUTPUT_B_O)
    else $error("non-inverted output not set on down match");
  AST_OFF_PIN: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ctrl_reg.com_a == dspt_pkg::COM_OFF |-> !COMPARE_OUTPUT_A_OE_O)
    else $error("pin driven while output mode is off");
  AST_B_TOGGLE_OFF: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ctrl_reg.com_b == dspt_pkg::COM_TOGGLE |-> !COMPARE_OUTPUT_B_OE_O)
    else $error("channel b driven in reserved toggle mode");
  AST_MODE_IDLE: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (!pfc_mode && !wr_en) |=> $stable(counter_value_reg))
    else $error("counter moved outside dual-slope modes");
  AST_CMPA_TOP_FLAG: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (ctrl_reg.mode == dspt_pkg::MODE_PFC_CMPA && timer_tick && at_top) |=> status_reg[dspt_pkg::ST_CMPA])
    else $error("compare A flag not set at top");
  AST_BUF_HOLD: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && !(timer_tick && at_bottom)) |=> $stable(compare_value_b_reg))
    else $error("compare value reloaded away from bottom");
  AST_PERIOD: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (pfc_mode && timer_tick && at_bottom && period_clean_reg) |-> period_ticks_reg == {top_value, 1'b0})
    else $error("period is not twice the top value");
  AST_CLEAR: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (wr_en && PADDR_I == dspt_pkg::OFS_CLEAR) |=> ((status_reg & $past(clr) & ~$past(evt)) == 4'h0))
    else $error("status bit survived its clear");
  AST_PIN_GATE: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !ctrl_reg.dir_b |-> !COMPARE_OUTPUT_B_OE_O)
    else $error("pin driven while direction is input");
  AST_IRQ: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (|(evt & irq_en_reg) && !(wr_en && PADDR_I == dspt_pkg::OFS_ENABLE)) |=> IRQ_O)
    else $error("interrupt not raised by enabled event");
  COV_TOP: cover property (@(posedge MCLK_I) disable iff (RST_I) timer_tick && at_top && pfc_mode);
  COV_OVF: cover property (@(posedge MCLK_I) disable iff (RST_I) evt[dspt_pkg::ST_OVF]);
  COV_MATCH_DOWN: cover property (@(posedge MCLK_I) disable iff (RST_I) match_b && !slope_up);
  COV_TOGGLE_A: cover property (@(posedge MCLK_I) disable iff (RST_I) match_a && ctrl_reg.com_a == dspt_pkg::COM_TOGGLE);
  COV_STATUS_READ: cover property (@(posedge MCLK_I) disable iff (RST_I) rd_en && PADDR_I == dspt_pkg::OFS_STATUS);
endmodule : dspt_timer

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_DIV1 = 3'h1;
  localparam logic [2:0] PRE_DIV8 = 3'h2;
  logic        MCLK_I;
  logic        RST_I;
  logic        PSEL_I;
  logic        PENABLE_I;
  logic        PWRITE_I;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I;
  logic [31:0] PRDATA_O;
  logic        PREADY_O;
  logic        PSLVERR_O;
  logic        IRQ_O;
  logic        COMPARE_OUTPUT_A_O;
  logic        COMPARE_OUTPUT_A_OE_O;
  logic        COMPARE_OUTPUT_B_O;
  logic        COMPARE_OUTPUT_B_OE_O;
  int          n_errors;
  int          compares;
  logic [31:0] rd;

  dspt_timer dut (
    .MCLK_I                (MCLK_I),
    .RST_I                 (RST_I),
    .PSEL_I                (PSEL_I),
    .PENABLE_I             (PENABLE_I),
    .PWRITE_I              (PWRITE_I),
    .PADDR_I               (PADDR_I),
    .PWDATA_I              (PWDATA_I),
    .PRDATA_O              (PRDATA_O),
    .PREADY_O              (PREADY_O),
    .PSLVERR_O             (PSLVERR_O),
    .IRQ_O                 (IRQ_O),
    .COMPARE_OUTPUT_A_O    (COMPARE_OUTPUT_A_O),
    .COMPARE_OUTPUT_A_OE_O (COMPARE_OUTPUT_A_OE_O),
    .COMPARE_OUTPUT_B_O    (COMPARE_OUTPUT_B_O),
    .COMPARE_OUTPUT_B_OE_O (COMPARE_OUTPUT_B_OE_O)
  );

  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end

  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] data);
    int n;
    @(posedge MCLK_I);
    PSEL_I    <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I  <= wr;
    PADDR_I   <= a;
    PWDATA_I  <= wd;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 50);
    data = PRDATA_O;
    compares++;
    if (PSLVERR_O !== 1'b0) begin
      n_errors++;
      $display("wrong value at %0t: slave error", $time);
    end
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      $display("wrong value at %0t: no ready", $time);
      close_out();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    apb(1'b1, a, wd, dummy);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] data;
    apb(1'b0, a, 32'h0000_0000, data);
    chk(data, exp, what);
  endtask : rchk

  function automatic logic [31:0] cfg(input logic [3:0] m, input dspt_pkg::dspt_com_t ca,
                                      input dspt_pkg::dspt_com_t cb, input logic [2:0] p,
                                      input logic da, input logic db);
    dspt_pkg::dspt_ctrl_t c;
    c.mode     = m;
    c.com_a    = ca;
    c.com_b    = cb;
    c.prescale = p;
    c.dir_a    = da;
    c.dir_b    = db;
    return {19'h0_0000, c};
  endfunction : cfg

  // high-time counts over whole periods do not depend on where the window starts
  task automatic run(input logic [31:0] c, input logic [15:0] top, input logic [15:0] cmpa,
                     input logic [15:0] cmpb, input int cyc, input logic [31:0] ea, input logic [31:0] eb);
    logic [31:0] ha;
    logic [31:0] hb;
    // park the counter at zero so a smaller top never leaves it stranded above
    wr(dspt_pkg::OFS_CTRL, c & ~(32'h0000_0007 << dspt_pkg::CTRL_PRE_LSB));
    wr(dspt_pkg::OFS_COUNT, 32'h0000_0000);
    wr(dspt_pkg::OFS_CAPTOP, {16'h0000, top});
    wr(dspt_pkg::OFS_CMPA, {16'h0000, cmpa});
    wr(dspt_pkg::OFS_CMPB, {16'h0000, cmpb});
    wr(dspt_pkg::OFS_CTRL, c);
    repeat (cyc) @(posedge MCLK_I);
    ha = 32'h0000_0000;
    hb = 32'h0000_0000;
    repeat (cyc) begin
      @(posedge MCLK_I);
      ha = ha + {31'h0000_0000, COMPARE_OUTPUT_A_O};
      hb = hb + {31'h0000_0000, COMPARE_OUTPUT_B_O};
    end
    chk(ha, ea, "high time a");
    chk(hb, eb, "high time b");
  endtask : run

  initial begin
    n_errors  = 0;
    compares  = 0;
    RST_I     = 1'b1;
    PSEL_I    = 1'b0;
    PENABLE_I = 1'b0;
    PWRITE_I  = 1'b0;
    PADDR_I   = 8'h00;
    PWDATA_I  = 32'h0000_0000;
    repeat (10) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rchk(dspt_pkg::OFS_CTRL, dspt_pkg::CTRL_RESET, "ctrl reset");
    rchk(dspt_pkg::OFS_CAPTOP, 32'h0000_FFFF, "top reset");
    rchk(dspt_pkg::OFS_STATUS, 32'h0000_0000, "status reset");
    rchk(dspt_pkg::OFS_COUNT, 32'h8000_0000, "count reset");
    rchk(8'h20, 32'h0000_0000, "unmapped read");
    rchk(dspt_pkg::OFS_CLEAR, 32'h0000_0000, "clear reads zero");
    chk({31'h0, IRQ_O}, 32'h0000_0000, "irq reset");
    run(cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_NONINV, dspt_pkg::COM_NONINV, PRE_DIV1, 1'b1, 1'b1),
        16'h0005, 16'h0002, 16'h0000, 100, 40, 0);
    chk({31'h0, COMPARE_OUTPUT_A_OE_O}, 32'h0000_0001, "drive a");
    run(cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_INV, dspt_pkg::COM_NONINV, PRE_DIV1, 1'b1, 1'b1),
        16'h0005, 16'h0002, 16'h0005, 100, 60, 100);
    run(cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_INV, dspt_pkg::COM_INV, PRE_DIV1, 1'b1, 1'b1),
        16'h0005, 16'h0002, 16'h0000, 100, 60, 100);
    run(cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_INV, dspt_pkg::COM_NONINV, PRE_DIV8, 1'b1, 1'b1),
        16'h0005, 16'h0002, 16'h0001, 800, 480, 160);
    run(cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_NONINV, dspt_pkg::COM_INV, PRE_DIV1, 1'b1, 1'b1),
        dspt_pkg::TOP_MIN, 16'h0001, 16'h0002, 60, 20, 20);
    run(cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_TOGGLE, dspt_pkg::COM_NONINV, PRE_DIV1, 1'b1, 1'b1),
        16'h0002, 16'h0006, 16'h0003, 120, 60, 60);
    wr(dspt_pkg::OFS_CTRL,
       cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_TOGGLE, dspt_pkg::COM_TOGGLE, PRE_DIV1, 1'b1, 1'b1));
    repeat (2) @(posedge MCLK_I);
    chk({31'h0, COMPARE_OUTPUT_A_OE_O}, 32'h0000_0001, "toggle a driven");
    chk({31'h0, COMPARE_OUTPUT_B_OE_O}, 32'h0000_0000, "toggle b reserved");
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_OFF, dspt_pkg::COM_NONINV, PRE_DIV1, 1'b1, 1'b0));
    repeat (2) @(posedge MCLK_I);
    chk({31'h0, COMPARE_OUTPUT_A_OE_O}, 32'h0000_0000, "mode zero off");
    chk({31'h0, COMPARE_OUTPUT_B_OE_O}, 32'h0000_0000, "direction in");
    wr(dspt_pkg::OFS_CTRL, cfg(4'h0, dspt_pkg::COM_TOGGLE, dspt_pkg::COM_OFF, PRE_DIV1, 1'b1, 1'b1));
    repeat (2) @(posedge MCLK_I);
    chk({31'h0, COMPARE_OUTPUT_A_OE_O}, 32'h0000_0000, "toggle upper bit clear");
    // stop the tick before clearing so no flag can be set in flight
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_OFF, dspt_pkg::COM_OFF, PRE_STOP, 1'b0, 1'b0));
    wr(dspt_pkg::OFS_CLEAR, 32'h0000_000F);
    wr(dspt_pkg::OFS_ENABLE, 32'h0000_0000);
    rchk(dspt_pkg::OFS_STATUS, 32'h0000_0000, "status cleared");
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_OFF, dspt_pkg::COM_OFF, PRE_DIV1, 1'b0, 1'b0));
    repeat (60) @(posedge MCLK_I);
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CMPA, dspt_pkg::COM_OFF, dspt_pkg::COM_OFF, PRE_STOP, 1'b0, 1'b0));
    rchk(dspt_pkg::OFS_STATUS, 32'h0000_0007, "flags top from a");
    chk({31'h0, IRQ_O}, 32'h0000_0000, "irq masked");
    wr(dspt_pkg::OFS_ENABLE, 32'h0000_0002);
    @(posedge MCLK_I);
    chk({31'h0, IRQ_O}, 32'h0000_0001, "irq enabled");
    wr(dspt_pkg::OFS_CLEAR, 32'h0000_000F);
    @(posedge MCLK_I);
    chk({31'h0, IRQ_O}, 32'h0000_0000, "irq cleared");
    wr(dspt_pkg::OFS_CMPA, 32'h0000_0002);
    wr(dspt_pkg::OFS_CAPTOP, 32'h0000_0005);
    wr(dspt_pkg::OFS_COUNT, 32'h0000_0000);
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_OFF, dspt_pkg::COM_OFF, PRE_DIV1, 1'b0, 1'b0));
    repeat (60) @(posedge MCLK_I);
    wr(dspt_pkg::OFS_CTRL, cfg(dspt_pkg::MODE_PFC_CAPTOP, dspt_pkg::COM_OFF, dspt_pkg::COM_OFF, PRE_STOP, 1'b0, 1'b0));
    rchk(dspt_pkg::OFS_STATUS, 32'h0000_000F, "flags top from capture");
    wr(dspt_pkg::OFS_COUNT, 32'h0000_0003);
    apb(1'b0, dspt_pkg::OFS_COUNT, 32'h0000_0000, rd);
    chk({16'h0000, rd[15:0]}, 32'h0000_0003, "count load");
    close_out();
  end
endmodule : tb
